// file: design/cit_timer_block.sv
// Top of the camera output timers with raw/absolute settings and line status
//
// Notes on behaviour
// - Each timer's delay equals its raw delay count times the delay base.
// - Delay base resets to one microsecond, also its minimum.
// - Raw delay counts 0 to 4095 in a 12-bit field.
// - Delay base is written in whole microseconds.
// - One delay base shared by all four timers.
// - Absolute delay write stores absolute divided by the delay base.
// - Non-multiple absolute delay is replaced by the nearest value.
// - Readable absolute delay always equals raw times current base.
// - Each timer's pulse width equals raw duration times duration base.
// - Raw duration counts 1 to 4095; zero is never programmed.
// - Duration base resets to one microsecond, written in microseconds.
// - One duration base shared by all four timers.
// - Absolute duration write stores absolute divided by duration base.
// - Absolute duration read returns raw duration times duration base.
// - Raw duration changes show in the readable absolute duration.
// - Per-timer accesses act on the timer chosen by the selector.
// - Single-line status returns the selected output line level.
// - A 32-bit word shows every input and output line, one bit each.
// - After start: low for delay, high for duration, then low.
// - Exposure start is the only event starting a timer.
// - Timer n drives only output line n.
`timescale 1ns/1ps
module cit_timer_block #(
    parameter int unsigned NUM_TIMERS = cit_pkg::NUM_TIMERS,
    parameter int unsigned NUM_IN = cit_pkg::NUM_IN_LINES
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [cit_pkg::ADDR_W-1:0] addr,
    input wire logic [cit_pkg::DATA_W-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [cit_pkg::DATA_W-1:0] rdata,
    input wire logic exposure_start,
    input wire logic [NUM_IN-1:0] in_lines,
    output logic [NUM_TIMERS-1:0] out_lines
);
    localparam int unsigned RW = cit_pkg::RAW_W;
    localparam int unsigned BW = cit_pkg::BASE_W;
    localparam int unsigned AW = cit_pkg::ABS_W;
    localparam int unsigned DW = cit_pkg::DATA_W;

    // ---------------------------------------------------------------
    // Helper functions
    // ---------------------------------------------------------------
    // Nearest raw count for an absolute time, clamped to the field
    function automatic logic [RW-1:0] abs_to_raw(
        input logic [DW-1:0] abs_us,
        input logic [BW-1:0] base,
        input logic [RW-1:0] lo
    );
        logic [DW-1:0] q;
        logic [DW-1:0] r;
        q = abs_us / DW'(base);
        r = abs_us % DW'(base);
        // Round half up toward the closer multiple
        if ((r << 1) >= DW'(base)) begin
            q = q + 1'b1;
        end
        if (q > DW'(cit_pkg::RAW_MAX)) begin
            q = DW'(cit_pkg::RAW_MAX);
        end
        if (q < DW'(lo)) begin
            q = DW'(lo);
        end
        abs_to_raw = q[RW-1:0];
    endfunction : abs_to_raw

    // Base written in microseconds, never below the minimum
    function automatic logic [BW-1:0] clamp_base(input logic [DW-1:0] v);
        if (v[DW-1:BW] != '0) begin
            clamp_base = '1;
        end else if (v[BW-1:0] < cit_pkg::BASE_MIN) begin
            clamp_base = cit_pkg::BASE_MIN;
        end else begin
            clamp_base = v[BW-1:0];
        end
    endfunction : clamp_base

    // ---------------------------------------------------------------
    // Microsecond tick
    // ---------------------------------------------------------------
    logic [cit_pkg::TICK_CNT_W-1:0] tdiv_q, tdiv_d;
    logic tick;

    // divide clock to one tick per microsecond
    always_comb begin
        tick = (tdiv_q == cit_pkg::TICK_CNT_W'(cit_pkg::TICK_CYCLES - 1));
        tdiv_d = tick ? '0 : tdiv_q + 1'b1;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            tdiv_q <= '0;
        end else begin
            tdiv_q <= tdiv_d;
        end
    end

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    logic exp_m_q, exp_s_q, exp_p_q;
    logic [NUM_IN-1:0] in_m_q, in_s_q;
    logic start_pulse;

    // Two stages before use; the edge detector compares the second stage with a third
    always_ff @(posedge clk) begin
        if (srst) begin
            exp_m_q <= 1'b0;
            exp_s_q <= 1'b0;
            exp_p_q <= 1'b0;
            in_m_q <= '0;
            in_s_q <= '0;
        end else begin
            exp_m_q <= exposure_start;
            exp_s_q <= exp_m_q;
            exp_p_q <= exp_s_q;
            in_m_q <= in_lines;
            in_s_q <= in_m_q;
        end
    end

    assign start_pulse = exp_s_q && !exp_p_q;

    // ---------------------------------------------------------------
    // Settings registers
    // ---------------------------------------------------------------
    logic [cit_pkg::SEL_W-1:0] tsel_q, tsel_d, lsel_q, lsel_d;
    logic [BW-1:0] dbase_q, dbase_d, ubase_q, ubase_d;
    logic [RW-1:0] dly_raw_q [NUM_TIMERS];
    logic [RW-1:0] dly_raw_d [NUM_TIMERS];
    logic [RW-1:0] dur_raw_q [NUM_TIMERS];
    logic [RW-1:0] dur_raw_d [NUM_TIMERS];
    logic [NUM_TIMERS-1:0] busy;

    // Next values of shared and selector registers
    always_comb begin
        tsel_d = tsel_q;
        lsel_d = lsel_q;
        dbase_d = dbase_q;
        ubase_d = ubase_q;
        if (wr_en) begin
            unique case (addr)
                cit_pkg::REG_TMR_SEL: tsel_d = wdata[cit_pkg::SEL_W-1:0];
                cit_pkg::REG_LINE_SEL: lsel_d = wdata[cit_pkg::SEL_W-1:0];
                cit_pkg::REG_DLY_BASE: dbase_d = clamp_base(wdata);
                cit_pkg::REG_DUR_BASE: ubase_d = clamp_base(wdata);
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            tsel_q <= '0;
            lsel_q <= '0;
            dbase_q <= cit_pkg::BASE_RST;
            ubase_q <= cit_pkg::BASE_RST;
        end else begin
            tsel_q <= tsel_d;
            lsel_q <= lsel_d;
            dbase_q <= dbase_d;
            ubase_q <= ubase_d;
        end
    end

    // ---------------------------------------------------------------
    // Per-timer raw counts and timers
    // ---------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NUM_TIMERS; gi++) begin : g_tmr
            logic sel_hit;
            assign sel_hit = wr_en && (tsel_q == cit_pkg::SEL_W'(gi));

            // only the selected timer takes writes
            always_comb begin
                dly_raw_d[gi] = dly_raw_q[gi];
                dur_raw_d[gi] = dur_raw_q[gi];
                if (sel_hit) begin
                    unique case (addr)
                        cit_pkg::REG_DLY_RAW: dly_raw_d[gi] = wdata[RW-1:0];
                        cit_pkg::REG_DLY_ABS: dly_raw_d[gi] =
                            abs_to_raw(wdata, dbase_q, '0);
                        cit_pkg::REG_DUR_RAW: dur_raw_d[gi] =
                            (wdata[RW-1:0] < cit_pkg::DUR_RAW_MIN) ?
                            cit_pkg::DUR_RAW_MIN : wdata[RW-1:0];
                        cit_pkg::REG_DUR_ABS: dur_raw_d[gi] =
                            abs_to_raw(wdata, ubase_q, cit_pkg::DUR_RAW_MIN);
                        default: ;
                    endcase
                end
            end

            always_ff @(posedge clk) begin
                if (srst) begin
                    dly_raw_q[gi] <= cit_pkg::DLY_RAW_RST;
                    dur_raw_q[gi] <= cit_pkg::DUR_RAW_RST;
                end else begin
                    dly_raw_q[gi] <= dly_raw_d[gi];
                    dur_raw_q[gi] <= dur_raw_d[gi];
                end
            end

            // timer n feeds output line n only
            cit_pulse_timer u_tmr (
                .clk(clk),
                .srst(srst),
                .tick(tick),
                .start(start_pulse),
                .dly_raw(dly_raw_q[gi]),
                .dur_raw(dur_raw_q[gi]),
                .dly_base(dbase_q),
                .dur_base(ubase_q),
                .pulse(out_lines[gi]),
                .busy(busy[gi])
            );
        end
    endgenerate

    // ---------------------------------------------------------------
    // Read path
    // ---------------------------------------------------------------
    logic [DW-1:0] rdata_q, rdata_d;
    logic [DW-1:0] line_all;

    // all lines in one word, outputs above inputs
    always_comb begin
        line_all = '0;
        line_all[cit_pkg::STAT_IN_LSB +: NUM_IN] = in_s_q;
        line_all[cit_pkg::STAT_OUT_LSB +: NUM_TIMERS] = out_lines;
    end

    // Read mux; absolute values are products so they track any change
    always_comb begin
        rdata_d = '0;
        if (rd_en) begin
            unique case (addr)
                cit_pkg::REG_TMR_SEL: rdata_d = DW'(tsel_q);
                cit_pkg::REG_LINE_SEL: rdata_d = DW'(lsel_q);
                cit_pkg::REG_DLY_RAW: rdata_d = DW'(dly_raw_q[tsel_q]);
                cit_pkg::REG_DUR_RAW: rdata_d = DW'(dur_raw_q[tsel_q]);
                cit_pkg::REG_DLY_BASE: rdata_d = DW'(dbase_q);
                cit_pkg::REG_DUR_BASE: rdata_d = DW'(ubase_q);
                // absolute delay is raw times base
                cit_pkg::REG_DLY_ABS: rdata_d =
                    DW'(AW'(dly_raw_q[tsel_q]) * AW'(dbase_q));
                cit_pkg::REG_DUR_ABS: rdata_d =
                    DW'(AW'(dur_raw_q[tsel_q]) * AW'(ubase_q));
                cit_pkg::REG_LINE_STAT: rdata_d = DW'(out_lines[lsel_q]);
                cit_pkg::REG_LINE_ALL: rdata_d = line_all;
                cit_pkg::REG_TMR_BUSY: rdata_d = DW'(busy);
                default: rdata_d = '0;
            endcase
        end
    end

    // Read data stand one cycle after the strobe, zero otherwise
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata = rdata_q;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    sequence s_idle_start;
        !busy[0] && start_pulse;
    endsequence

    start_low_a: assert property (@(posedge clk) disable iff (srst)
        (s_idle_start and (dly_raw_q[0] != '0)) |=> !out_lines[0])
        else $error("timer output high at start of delay");

    base_reset_a: assert property (@(posedge clk)
        srst |=> dbase_q == cit_pkg::BASE_RST
        && ubase_q == cit_pkg::BASE_RST)
        else $error("time base not one after reset");

    dur_nonzero_a: assert property (@(posedge clk) disable iff (srst)
        dur_raw_q[tsel_q] != '0)
        else $error("raw duration is zero");

    base_min_a: assert property (@(posedge clk) disable iff (srst)
        dbase_q >= cit_pkg::BASE_MIN && ubase_q >= cit_pkg::BASE_MIN)
        else $error("time base below minimum");

    tick_gap_a: assert property (@(posedge clk) disable iff (srst)
        tick |=> !tick [*8])
        else $error("microsecond tick too frequent");

    // absolute write of exact multiple stores quotient
    abs_store_a: assert property (@(posedge clk) disable iff (srst)
        wr_en && addr == cit_pkg::REG_DLY_ABS && tsel_q == '0
        && wdata == 32'h0000_0096 && dbase_q == 16'h0032
        |=> dly_raw_q[0] == 12'h003)
        else $error("absolute delay stored wrong raw");

    // line status read follows the selected output
    line_stat_a: assert property (@(posedge clk) disable iff (srst)
        rd_en && addr == cit_pkg::REG_LINE_STAT
        |=> rdata[0] == $past(out_lines[lsel_q]))
        else $error("line status mismatch");

    // busy timer keeps its phase across a start
    busy_ignore_a: assert property (@(posedge clk) disable iff (srst)
        busy[0] && start_pulse && !tick
        |=> busy[0] && out_lines[0] == $past(out_lines[0]))
        else $error("start disturbed a running timer");
endmodule : cit_timer_block

// file: design/cit_pkg.sv
// Package: register map, field widths and timing constants of the camera timers
package cit_pkg;
    // Clock and microsecond tick
    localparam int unsigned CLK_FREQ_MHZ = 40;
    localparam int unsigned TICK_US = 1;
    localparam int unsigned TICK_CYCLES = CLK_FREQ_MHZ * TICK_US;
    localparam int unsigned TICK_CNT_W = 6;

    // Widths
    localparam int unsigned NUM_TIMERS = 4;
    localparam int unsigned SEL_W = 2;
    localparam int unsigned RAW_W = 12;
    localparam int unsigned BASE_W = 16;
    localparam int unsigned ABS_W = 28;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned NUM_IN_LINES = 2;

    // Field values
    localparam logic [RAW_W-1:0] RAW_MAX = 12'hFFF;
    localparam logic [RAW_W-1:0] DLY_RAW_RST = 12'h000;
    localparam logic [RAW_W-1:0] DUR_RAW_RST = 12'h001;
    localparam logic [RAW_W-1:0] DUR_RAW_MIN = 12'h001;
    localparam logic [BASE_W-1:0] BASE_RST = 16'h0001;
    localparam logic [BASE_W-1:0] BASE_MIN = 16'h0001;

    // Status word layout: inputs low, outputs from bit 2
    localparam int unsigned STAT_IN_LSB = 0;
    localparam int unsigned STAT_OUT_LSB = 2;

    // Register offsets
    localparam logic [ADDR_W-1:0] REG_TMR_SEL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_DLY_RAW = 8'h04;
    localparam logic [ADDR_W-1:0] REG_DLY_BASE = 8'h08;
    localparam logic [ADDR_W-1:0] REG_DLY_ABS = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_DUR_RAW = 8'h10;
    localparam logic [ADDR_W-1:0] REG_DUR_BASE = 8'h14;
    localparam logic [ADDR_W-1:0] REG_DUR_ABS = 8'h18;
    localparam logic [ADDR_W-1:0] REG_LINE_SEL = 8'h1C;
    localparam logic [ADDR_W-1:0] REG_LINE_STAT = 8'h20;
    localparam logic [ADDR_W-1:0] REG_LINE_ALL = 8'h24;
    localparam logic [ADDR_W-1:0] REG_TMR_BUSY = 8'h28;
endpackage : cit_pkg

// file: design/cit_pulse_timer.sv
// One delay-then-pulse timer driven by the shared microsecond tick
`timescale 1ns/1ps
module cit_pulse_timer #(
    parameter int unsigned RAW_W = cit_pkg::RAW_W,
    parameter int unsigned BASE_W = cit_pkg::BASE_W
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic tick,
    input wire logic start,
    input wire logic [RAW_W-1:0] dly_raw,
    input wire logic [RAW_W-1:0] dur_raw,
    input wire logic [BASE_W-1:0] dly_base,
    input wire logic [BASE_W-1:0] dur_base,
    output logic pulse,
    output logic busy
);
    typedef enum logic [2:0] {
        CIT_IDLE = 3'b001,
        CIT_DLY = 3'b010,
        CIT_HIGH = 3'b100
    } cit_tstate_t;

    cit_tstate_t st_q, st_d;
    logic [BASE_W-1:0] pre_q, pre_d;
    logic [RAW_W-1:0] cnt_q, cnt_d;
    logic unit_end;

    // -------------------------------------------------------------
    // Sequencer
    // -------------------------------------------------------------
    // A unit ends when the prescaler has seen base ticks
    assign unit_end = tick && (pre_q == dly_base - 1'b1 && st_q == CIT_DLY
                      || pre_q == dur_base - 1'b1 && st_q == CIT_HIGH);

    // Next state; settings are read live so changes apply at once
    always_comb begin
        st_d = st_q;
        pre_d = pre_q;
        cnt_d = cnt_q;
        unique case (st_q)
            CIT_IDLE: begin
                pre_d = '0;
                cnt_d = '0;
                if (start) begin
                    st_d = (dly_raw == '0) ? CIT_HIGH : CIT_DLY;
                end
            end
            CIT_DLY: begin
                if (tick) begin
                    pre_d = unit_end ? '0 : pre_q + 1'b1;
                end
                if (unit_end) begin
                    cnt_d = cnt_q + 1'b1;
                    if (cnt_q + 1'b1 >= dly_raw) begin
                        st_d = CIT_HIGH;
                        cnt_d = '0;
                    end
                end
            end
            CIT_HIGH: begin
                if (tick) begin
                    pre_d = unit_end ? '0 : pre_q + 1'b1;
                end
                if (unit_end) begin
                    cnt_d = cnt_q + 1'b1;
                    if (cnt_q + 1'b1 >= dur_raw) begin
                        st_d = CIT_IDLE;
                    end
                end
            end
            default: st_d = CIT_IDLE;
        endcase
    end

    // start ignored while busy, as only idle reacts
    always_ff @(posedge clk) begin
        if (srst) begin
            st_q <= CIT_IDLE;
            pre_q <= '0;
            cnt_q <= '0;
        end else begin
            st_q <= st_d;
            pre_q <= pre_d;
            cnt_q <= cnt_d;
        end
    end

    // low in delay, high in duration
    assign pulse = (st_q == CIT_HIGH);
    assign busy = (st_q != CIT_IDLE);
endmodule : cit_pulse_timer

// file: testbench/cit_timer_block_tb.sv
// Self-checking testbench for the camera output timer block
`timescale 1ns/1ps
module cit_timer_block_tb;
    // ------------------------------------------------------------
    // Signals and counters
    // ------------------------------------------------------------
    localparam int CYC_US = 40;
    localparam int TIMEOUT = 20000;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [cit_pkg::ADDR_W-1:0] addr = 8'h00;
    logic [cit_pkg::DATA_W-1:0] wdata = 32'h0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [cit_pkg::DATA_W-1:0] rdata;
    logic exposure_start = 1'b0;
    logic [1:0] in_lines = 2'h1;
    logic [3:0] out_lines;
    logic [3:0] prev;
    int fail_count = 0;
    int checks = 0;
    int cyc = 0;
    int rise [4];
    int fall [4];
    int nrise [4];

    // Clock of 25 ns period
    always #12.5 clk = ~clk;

    cit_timer_block u_cit_timer_block (
        .clk(clk),
        .srst(srst),
        .addr(addr),
        .wdata(wdata),
        .wr_en(wr_en),
        .rd_en(rd_en),
        .rdata(rdata),
        .exposure_start(exposure_start),
        .in_lines(in_lines),
        .out_lines(out_lines)
    );

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish;
        if (fail_count == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t read %h expected %h", $time, got, exp);
        end
    endtask : check

    // Bounds on measured cycle counts, which are bench values
    task automatic check_rng(input int v, input int lo, input int hi);
        checks++;
        if (v < lo || v > hi) begin
            fail_count++;
            $display("[ERR] %0t count %0d outside %0d..%0d", $time, v, lo, hi);
        end
    endtask : check_rng

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : reg_wr

    // Read data stand only in the cycle after the strobe
    task automatic expect_rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        check(rdata, exp);
    endtask : expect_rd

    // Hang guard: a run past the ceiling counts as a mismatch
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == TIMEOUT) begin
            fail_count++;
            $display("[ERR] %0t run did not finish", $time);
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        // Reset values of bases and counts
        expect_rd(cit_pkg::REG_DLY_BASE, 32'h1);
        expect_rd(cit_pkg::REG_DUR_BASE, 32'h1);
        expect_rd(cit_pkg::REG_DLY_RAW, 32'h0);
        expect_rd(cit_pkg::REG_DUR_RAW, 32'h1);
        expect_rd(cit_pkg::REG_DUR_ABS, 32'h1);
        // Raw limits, zero duration refused, zero base raised to one
        reg_wr(cit_pkg::REG_DLY_RAW, 32'hFFF);
        expect_rd(cit_pkg::REG_DLY_RAW, 32'hFFF);
        reg_wr(cit_pkg::REG_DUR_RAW, 32'h0);
        expect_rd(cit_pkg::REG_DUR_RAW, 32'h1);
        reg_wr(cit_pkg::REG_DLY_BASE, 32'h0);
        expect_rd(cit_pkg::REG_DLY_BASE, 32'h1);
        // Unmapped place reads zero and ignores writes
        reg_wr(8'hFC, 32'h5);
        expect_rd(8'hFC, 32'h0);
        // Absolute delay through a 50 us base, then base change
        reg_wr(cit_pkg::REG_DLY_BASE, 32'd50);
        reg_wr(cit_pkg::REG_DLY_ABS, 32'd150);
        expect_rd(cit_pkg::REG_DLY_RAW, 32'd3);
        reg_wr(cit_pkg::REG_DLY_ABS, 32'd170);
        expect_rd(cit_pkg::REG_DLY_ABS, 32'd150);
        reg_wr(cit_pkg::REG_DLY_ABS, 32'd180);
        expect_rd(cit_pkg::REG_DLY_ABS, 32'd200);
        reg_wr(cit_pkg::REG_DLY_BASE, 32'd10);
        expect_rd(cit_pkg::REG_DLY_ABS, 32'd40);
        reg_wr(cit_pkg::REG_DLY_RAW, 32'd7);
        expect_rd(cit_pkg::REG_DLY_ABS, 32'd70);
        // Absolute duration through a 50 us base
        reg_wr(cit_pkg::REG_DUR_BASE, 32'd50);
        reg_wr(cit_pkg::REG_DUR_ABS, 32'd100);
        expect_rd(cit_pkg::REG_DUR_RAW, 32'd2);
        reg_wr(cit_pkg::REG_DUR_RAW, 32'd9);
        expect_rd(cit_pkg::REG_DUR_ABS, 32'd450);
        // Second timer keeps its own counts but sees the shared bases
        reg_wr(cit_pkg::REG_TMR_SEL, 32'd1);
        reg_wr(cit_pkg::REG_DUR_RAW, 32'd3);
        expect_rd(cit_pkg::REG_DUR_ABS, 32'd150);
        reg_wr(cit_pkg::REG_DLY_RAW, 32'd2);
        expect_rd(cit_pkg::REG_DLY_ABS, 32'd20);
        reg_wr(cit_pkg::REG_TMR_SEL, 32'd0);
        expect_rd(cit_pkg::REG_DUR_RAW, 32'd9);

        // Distinct settings per timer so that each line is told apart
        reg_wr(cit_pkg::REG_DLY_BASE, 32'd2);
        reg_wr(cit_pkg::REG_DUR_BASE, 32'd3);
        for (int i = 0; i < 4; i++) begin
            reg_wr(cit_pkg::REG_TMR_SEL, 32'(i));
            reg_wr(cit_pkg::REG_DLY_RAW, 32'(3 + 2 * i));
            reg_wr(cit_pkg::REG_DUR_RAW, 32'(4 + i));
            rise[i] = -1;
            fall[i] = -1;
            nrise[i] = 0;
        end
        // Later start pulses hit every busy timer and must be lost
        prev = 4'h0;
        for (int n = 0; n < 2000; n++) begin
            @(posedge clk);
            exposure_start <= (n < 10) || (n >= 200 && n < 210)
                || (n >= 400 && n < 410);
            #1;
            for (int i = 0; i < 4; i++) begin
                if (out_lines[i] && !prev[i]) begin
                    nrise[i]++;
                    rise[i] = n;
                end
                if (!out_lines[i] && prev[i]) begin
                    fall[i] = n;
                end
            end
            prev = out_lines;
        end
        // First microsecond may be short since the tick runs free
        for (int i = 0; i < 4; i++) begin
            check_rng(nrise[i], 1, 1);
            check_rng(rise[i], (3 + 2 * i) * 2 * CYC_US - CYC_US,
                (3 + 2 * i) * 2 * CYC_US + 6);
            check_rng(fall[i] - rise[i], (4 + i) * 3 * CYC_US - 2,
                (4 + i) * 3 * CYC_US + 2);
        end

        // Status words while lines 0 and 2 are high, 1 and 3 waiting
        reg_wr(cit_pkg::REG_DLY_BASE, 32'd1);
        reg_wr(cit_pkg::REG_DUR_BASE, 32'd1);
        for (int i = 0; i < 4; i++) begin
            reg_wr(cit_pkg::REG_TMR_SEL, 32'(i));
            reg_wr(cit_pkg::REG_DLY_RAW, (i % 2 == 0) ? 32'd0 : 32'd200);
            reg_wr(cit_pkg::REG_DUR_RAW, 32'd100);
        end
        @(posedge clk);
        in_lines <= 2'h2;
        exposure_start <= 1'b1;
        repeat (30) @(posedge clk);
        exposure_start <= 1'b0;
        expect_rd(cit_pkg::REG_LINE_ALL, 32'h16);
        expect_rd(cit_pkg::REG_TMR_BUSY, 32'hF);
        for (int i = 0; i < 4; i++) begin
            reg_wr(cit_pkg::REG_LINE_SEL, 32'(i));
            expect_rd(cit_pkg::REG_LINE_STAT, 32'((i + 1) % 2));
        end
        tally_and_finish();
    end
endmodule : cit_timer_block_tb
